// file: logic/instr_decoder_pkg.sv
package instr_decoder_pkg;

    // instruction class
    typedef enum logic [1:0] {
        group_byte,
        group_bit,
        group_literal
    } group_t;

    // phase counter state of the sequencer
    typedef struct packed {
        logic [1:0] phase;      // oscillator cycle within the instruction cycle
        logic [1:0] remaining;  // instruction cycles left after the current one
        logic       first;      // current cycle is the first of its instruction
    } seq_state_t;

endpackage

// file: logic/instr_decoder_regs.svh
`ifndef INSTR_DECODER_REGS_SVH
`define INSTR_DECODER_REGS_SVH

// instruction word and field layout
`define WORD_W            14
`define FILE_ADDR_LSB     0
`define FILE_ADDR_W       7
`define DEST_BIT          7
`define BIT_POS_LSB       7
`define BIT_POS_W         3
`define LIT8_W            8
`define LIT11_W           11
`define LIT9_W            9
`define PTR_OFS_BIT       6
`define PTR_INC_BIT       2
`define INC_MODE_W        2
`define CYCLES_W          2

// oscillator cycles per instruction cycle
`define PHASES_PER_CYCLE  4

// word executed after reset (no operation)
`define RESET_WORD        14'h0000

// major opcode patterns, compared against the top bits of the word
`define OP_DEC_SKIP       6'h0B
`define OP_INC_SKIP       6'h0F
`define OP_SKIP_CLR       4'h6
`define OP_SKIP_SET       4'h7
`define OP_SUB_CALL       3'h4
`define OP_JUMP           3'h5
`define OP_REL_BRANCH     5'h19
`define OP_RET_LIT        6'h34
`define OP_PTR_OFS        6'h3F
`define OP_PTR_INC        11'h002
`define OP_MISC_HI        7'h00

// full-word control codes
`define OP_RETURN         14'h0008
`define OP_RET_INT        14'h0009
`define OP_CALL_W         14'h000A
`define OP_BRANCH_W       14'h000B

// file addresses whose upper six bits are zero are the indirect data registers
`define INDIRECT_ADDR_HI  6'h00

`endif

// file: logic/instr_field_splitter.sv
`timescale 1ns/10ps
`include "instr_decoder_regs.svh"

module instr_field_splitter (
    input  wire logic [`WORD_W-1:0]      word,           // instruction word
    input  wire logic [1:0]              ptr_in_prog,    // pointer n aims at program memory
    output instr_decoder_pkg::group_t    group,          // instruction class
    output logic [`FILE_ADDR_W-1:0]      file_addr,      // file register address
    output logic                         dest_to_file,   // result to file register
    output logic [`BIT_POS_W-1:0]        bit_pos,        // bit position
    output logic [`LIT8_W-1:0]           lit8,           // general literal
    output logic [`LIT11_W-1:0]          lit11,          // jump and call target
    output logic [`LIT9_W-1:0]           lit9,           // relative branch offset
    output logic                         ptr_num,        // pointer number
    output logic [`INC_MODE_W-1:0]       inc_mode,       // increment mode
    output logic                         names_file,     // word names a file register
    output logic                         is_call,        // call class
    output logic                         is_return,      // return class
    output logic                         is_branch,      // jump, branch or skip class
    output logic                         indirect_prog,  // indirect access to program memory
    output logic [`CYCLES_W-1:0]         cycles          // instruction cycles needed
);

    logic is_ptr_ofs;  // pointer offset form
    logic is_ptr_inc;  // pointer increment form
    logic is_misc;     // opcode-only control form
    logic is_indirect_data_register;     // file address is an indirect data register

    // byte ops in the upper literal block
    function automatic logic upper_byte_op(input logic [5:0] major);
        upper_byte_op = (major == 6'h35) || (major == 6'h36) || (major == 6'h37) ||
                        (major == 6'h3B) || (major == 6'h3D);
    endfunction

    // fields are sliced straight out of the one word, no extension word exists
    assign file_addr    = word[`FILE_ADDR_LSB +: `FILE_ADDR_W];          // [RL1] [RL9]
    assign dest_to_file = word[`DEST_BIT];                                // [RL16] [RL11]
    assign bit_pos      = word[`BIT_POS_LSB +: `BIT_POS_W];               // [RL17] [RL10]
    assign lit8         = word[`LIT8_W-1:0];                              // [RL18]
    assign lit11        = word[`LIT11_W-1:0];                             // [RL18]
    assign lit9         = word[`LIT9_W-1:0];                              // [RL19]
    assign inc_mode     = word[`INC_MODE_W-1:0];
    assign is_ptr_ofs   = (word[13:8] == `OP_PTR_OFS);
    assign is_ptr_inc   = (word[13:3] == `OP_PTR_INC);
    assign is_misc      = (word[13:7] == `OP_MISC_HI);
    assign is_indirect_data_register      = (file_addr[6:1] == `INDIRECT_ADDR_HI);
    assign ptr_num      = is_ptr_ofs ? word[`PTR_OFS_BIT] : word[`PTR_INC_BIT]; // [RL12]

    // classification; the unused low bits of clear-working still reach the indirect data register compare
    always_comb begin
        if (word[13:12] == 2'b00 && !is_misc) begin
            group = instr_decoder_pkg::group_byte;                        // [RL2] [RL13]
        end else if (word[13:12] == 2'b01) begin
            group = instr_decoder_pkg::group_bit;                         // [RL2]
        end else if (word[13:12] == 2'b11 && upper_byte_op(word[13:8])) begin
            group = instr_decoder_pkg::group_byte;                        // [RL2]
        end else begin
            group = instr_decoder_pkg::group_literal;                     // [RL2]
        end
    end

    assign names_file = (group != instr_decoder_pkg::group_literal);     // [RL14]
    assign is_call    = (word[13:11] == `OP_SUB_CALL) || (word == `OP_CALL_W);       // [RL4]
    assign is_return  = (word == `OP_RETURN) || (word == `OP_RET_INT) ||
                        (word[13:8] == `OP_RET_LIT);                                  // [RL5]
    assign is_branch  = (word[13:11] == `OP_JUMP) || (word[13:9] == `OP_REL_BRANCH) ||
                        (word == `OP_BRANCH_W) || (word[13:8] == `OP_DEC_SKIP) ||
                        (word[13:8] == `OP_INC_SKIP) || (word[13:10] == `OP_SKIP_CLR) ||
                        (word[13:10] == `OP_SKIP_SET);                                // [RL6]

    // indirect reference while the chosen pointer aims at program memory
    always_comb begin
        if (names_file && is_indirect_data_register) begin
            indirect_prog = ptr_in_prog[file_addr[0]];                    // [RL7]
        end else if (is_ptr_ofs || is_ptr_inc) begin
            indirect_prog = ptr_in_prog[ptr_num];                         // [RL7]
        end else begin
            indirect_prog = 1'b0;
        end
    end

    // one cycle, two for flow changes, one more for program memory access
    assign cycles = ((is_call || is_return || is_branch) ? 2'd2 : 2'd1) +
                    (indirect_prog ? 2'd1 : 2'd0);                        // [RL3] [RL7]

endmodule

// file: logic/instr_phase_sequencer.sv
`timescale 1ns/10ps
`include "instr_decoder_regs.svh"

module instr_phase_sequencer (
    input  wire logic                   clk,           // oscillator clock
    input  wire logic                   rst,           // async reset, active high
    input  wire logic [`CYCLES_W-1:0]   cycles_needed, // count of the word being taken
    output logic      [1:0]             phase,         // current oscillator phase
    output logic                        first_cycle,   // in first instruction cycle
    output logic                        take_word      // last phase of last cycle
);

    instr_decoder_pkg::seq_state_t state;       // registered state
    instr_decoder_pkg::seq_state_t next_state;  // next state

    assign phase       = state.phase;
    assign first_cycle = state.first;

    // four phases make one instruction cycle; a new word is taken only at the end
    always_comb begin
        next_state = state;
        take_word  = (state.phase == 2'(`PHASES_PER_CYCLE - 1)) && (state.remaining == 2'd0);
        next_state.phase = state.phase + 2'd1;                                     // [RL8]
        if (take_word) begin
            next_state.remaining = cycles_needed - 2'd1;                           // [RL3]
            next_state.first     = 1'b1;
        end else if (state.phase == 2'(`PHASES_PER_CYCLE - 1)) begin
            // added cycle: the word fetched meanwhile is never taken
            next_state.remaining = state.remaining - 2'd1;                         // [RL21]
            next_state.first     = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '{phase: 2'd0, remaining: 2'd0, first: 1'b1};
        end else begin
            state <= next_state;
        end
    end

endmodule

// file: logic/instruction_word_decoder.sv
// Functional notes
// RL1: one 14-bit word holds all operands
// RL2: classify byte, bit, or literal/control group
// RL3: single cycle except listed multi-cycle cases
// RL4: calls take two instruction cycles
// RL5: all returns take two instruction cycles
// RL6: jumps, branches and skips take two cycles
// RL7: indirect program-memory reference adds one cycle
// RL8: instruction cycle is four oscillator cycles
// RL9: file address spans 0x00 to 0x7F
// RL10: bit field picks one of eight bits
// RL11: destination bit zero working, one file
// RL12: pointer number selects pointer zero or one
// RL13: don't-care encoding bits are ignored; the clear-working low bits still feed the indirect data register compare
// RL14: file register instructions do read-modify-write
// RL15: file register read even when only written
// RL16: destination bit sits above address field
// RL17: three-bit bit position above address field
// RL18: eleven-bit target, eight-bit general literal
// RL19: nine-bit relative branch offset
// RL20: cycle count and controls ready before phase zero
// RL21: added cycle discards fetch, no writes
`timescale 1ns/10ps
`include "instr_decoder_regs.svh"

module instruction_word_decoder (
    input  wire logic                    clk,            // oscillator clock, 250 MHz
    input  wire logic                    rst,            // async reset, active high
    input  wire logic [`WORD_W-1:0]      instr_word,     // word from program memory
    input  wire logic [1:0]              ptr_in_prog,    // pointer n aims at program memory
    output logic      [1:0]              phase,          // oscillator phase 0..3
    output logic                         cycle_start,    // first phase of an instr cycle
    output logic                         fetch_request,  // fetch the next word this cycle
    output logic                         discard_fetch,  // added cycle, fetched word dropped
    output logic [`WORD_W-1:0]           exec_word,      // word now executing
    output instr_decoder_pkg::group_t    exec_group,     // its class
    output logic [`FILE_ADDR_W-1:0]      exec_file_addr, // file register address
    output logic                         exec_dest_file, // result to file register
    output logic [`BIT_POS_W-1:0]        exec_bit_pos,   // bit position
    output logic [`LIT8_W-1:0]           exec_lit8,      // general literal
    output logic [`LIT11_W-1:0]          exec_lit11,     // jump and call target
    output logic [`LIT9_W-1:0]           exec_lit9,      // relative branch offset
    output logic                         exec_ptr_num,   // pointer number
    output logic [`INC_MODE_W-1:0]       exec_inc_mode,  // increment mode
    output logic                         exec_is_call,   // call class
    output logic                         exec_is_return, // return class
    output logic                         exec_is_branch, // jump, branch or skip class
    output logic                         exec_ind_prog,  // indirect access to program memory
    output logic [`CYCLES_W-1:0]         exec_cycles,    // instruction cycles of this word
    output logic                         file_read,      // read strobe, phase 1
    output logic                         file_write,     // file write strobe, phase 3
    output logic                         working_write   // working write strobe, phase 3
);

    // everything that the top holds, registered as one word
    typedef struct packed {
        logic                         cycle_start;
        logic                         fetch_request;
        logic                         discard_fetch;
        logic [`WORD_W-1:0]           word;
        instr_decoder_pkg::group_t    group;
        logic [`FILE_ADDR_W-1:0]      file_addr;
        logic                         dest_file;
        logic [`BIT_POS_W-1:0]        bit_pos;
        logic [`LIT8_W-1:0]           lit8;
        logic [`LIT11_W-1:0]          lit11;
        logic [`LIT9_W-1:0]           lit9;
        logic                         ptr_num;
        logic [`INC_MODE_W-1:0]       inc_mode;
        logic                         names_file;
        logic                         is_call;
        logic                         is_return;
        logic                         is_branch;
        logic                         ind_prog;
        logic [`CYCLES_W-1:0]         cycles;
        logic                         file_read;
        logic                         file_write;
        logic                         working_write;
    } top_state_t;

    top_state_t state;       // registered state
    top_state_t next_state;  // next state

    // decoder outputs for the incoming word
    instr_decoder_pkg::group_t    dec_group;      // class
    logic [`FILE_ADDR_W-1:0]      dec_file_addr;  // file address
    logic                         dec_dest_file;  // destination bit
    logic [`BIT_POS_W-1:0]        dec_bit_pos;    // bit position
    logic [`LIT8_W-1:0]           dec_lit8;       // general literal
    logic [`LIT11_W-1:0]          dec_lit11;      // jump target
    logic [`LIT9_W-1:0]           dec_lit9;       // branch offset
    logic                         dec_ptr_num;    // pointer number
    logic [`INC_MODE_W-1:0]       dec_inc_mode;   // increment mode
    logic                         dec_names_file; // names a file register
    logic                         dec_is_call;    // call class
    logic                         dec_is_return;  // return class
    logic                         dec_is_branch;  // flow change class
    logic                         dec_ind_prog;   // program memory indirect
    logic [`CYCLES_W-1:0]         dec_cycles;     // cycle count

    // sequencer outputs
    logic [1:0]                   seq_phase;      // current phase
    logic                         seq_first;      // first instruction cycle
    logic                         seq_take;       // word taken this edge

    // the word is decoded in the same phase it is taken, no extra pipeline stage
    instr_field_splitter u_split (
        .word          (instr_word),
        .ptr_in_prog   (ptr_in_prog),
        .group         (dec_group),
        .file_addr     (dec_file_addr),
        .dest_to_file  (dec_dest_file),
        .bit_pos       (dec_bit_pos),
        .lit8          (dec_lit8),
        .lit11         (dec_lit11),
        .lit9          (dec_lit9),
        .ptr_num       (dec_ptr_num),
        .inc_mode      (dec_inc_mode),
        .names_file    (dec_names_file),
        .is_call       (dec_is_call),
        .is_return     (dec_is_return),
        .is_branch     (dec_is_branch),
        .indirect_prog (dec_ind_prog),
        .cycles        (dec_cycles)
    );

    // four-phase counter and multi-cycle stretch
    instr_phase_sequencer u_seq (
        .clk           (clk),
        .rst           (rst),
        .cycles_needed (dec_cycles),
        .phase         (seq_phase),
        .first_cycle   (seq_first),
        .take_word     (seq_take)
    );

    // true when the executing word writes its result to the file register
    function automatic logic writes_file(input top_state_t s);
        // bit ops set or clear in place; bit skips only test, so they never write
        if (s.group == instr_decoder_pkg::group_bit) begin
            writes_file = !s.is_branch;
        end else begin
            writes_file = (s.group == instr_decoder_pkg::group_byte) && s.dest_file;
        end
    endfunction

    // next state: latch decoded word on take, then pace the strobes by phase
    always_comb begin
        next_state = state;
        // a new instruction cycle begins on the edge after phase 3
        next_state.cycle_start   = (seq_phase == 2'(`PHASES_PER_CYCLE - 1));   // [RL8]
        next_state.fetch_request = (seq_phase == 2'(`PHASES_PER_CYCLE - 1));
        if (seq_take) begin
            // the bundle is loaded on the same edge that phase 0 starts
            next_state.word          = instr_word;                             // [RL20]
            next_state.group         = dec_group;                              // [RL2]
            next_state.file_addr     = dec_file_addr;                          // [RL9]
            next_state.dest_file     = dec_dest_file;                          // [RL11]
            next_state.bit_pos       = dec_bit_pos;                            // [RL10]
            next_state.lit8          = dec_lit8;                               // [RL18]
            next_state.lit11         = dec_lit11;                              // [RL18]
            next_state.lit9          = dec_lit9;                               // [RL19]
            next_state.ptr_num       = dec_ptr_num;                            // [RL12]
            next_state.inc_mode      = dec_inc_mode;
            next_state.names_file    = dec_names_file;                         // [RL14]
            next_state.is_call       = dec_is_call;                            // [RL4]
            next_state.is_return     = dec_is_return;                          // [RL5]
            next_state.is_branch     = dec_is_branch;                          // [RL6]
            next_state.ind_prog      = dec_ind_prog;                           // [RL7]
            next_state.cycles        = dec_cycles;                             // [RL20] [RL3]
            next_state.discard_fetch = 1'b0;
        end else if (seq_phase == 2'(`PHASES_PER_CYCLE - 1)) begin
            // entering an added cycle: the word fetched meanwhile is dropped
            next_state.discard_fetch = 1'b1;                                   // [RL21]
        end
        // read in phase 1 of the first cycle for every file instruction,
        // even plain stores, so read side effects of the register still happen
        next_state.file_read = seq_first && (seq_phase == 2'd0) &&
                               !seq_take && state.names_file;                  // [RL14] [RL15]
        // writes fall in phase 3 of the first cycle only; added cycles stay quiet
        next_state.file_write    = seq_first && (seq_phase == 2'd2) &&
                                   writes_file(state);                         // [RL14] [RL21]
        next_state.working_write = seq_first && (seq_phase == 2'd2) &&
                                   (state.group == instr_decoder_pkg::group_byte) &&
                                   !state.dest_file;                           // [RL11] [RL21]
    end

    // state register; reset executes a no-operation word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '{cycle_start: 1'b0, fetch_request: 1'b0, discard_fetch: 1'b0,
                       word: `RESET_WORD, group: instr_decoder_pkg::group_literal,
                       file_addr: '0, dest_file: 1'b0, bit_pos: '0, lit8: '0,
                       lit11: '0, lit9: '0, ptr_num: 1'b0, inc_mode: '0,
                       names_file: 1'b0, is_call: 1'b0, is_return: 1'b0,
                       is_branch: 1'b0, ind_prog: 1'b0, cycles: 2'd1,
                       file_read: 1'b0, file_write: 1'b0, working_write: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the registers
    assign phase          = seq_phase;
    assign cycle_start    = state.cycle_start;
    assign fetch_request  = state.fetch_request;
    assign discard_fetch  = state.discard_fetch;
    assign exec_word      = state.word;
    assign exec_group     = state.group;
    assign exec_file_addr = state.file_addr;
    assign exec_dest_file = state.dest_file;
    assign exec_bit_pos   = state.bit_pos;
    assign exec_lit8      = state.lit8;
    assign exec_lit11     = state.lit11;
    assign exec_lit9      = state.lit9;
    assign exec_ptr_num   = state.ptr_num;
    assign exec_inc_mode  = state.inc_mode;
    assign exec_is_call   = state.is_call;
    assign exec_is_return = state.is_return;
    assign exec_is_branch = state.is_branch;
    assign exec_ind_prog  = state.ind_prog;
    assign exec_cycles    = state.cycles;
    assign file_read      = state.file_read;
    assign file_write     = state.file_write;
    assign working_write  = state.working_write;

endmodule

// file: tb/instr_decoder_properties.sv
`timescale 1ns/10ps
`include "instr_decoder_regs.svh"
module instr_decoder_checker (
    input wire logic                 clk,           // clock
    input wire logic                 rst,           // reset
    input wire logic [1:0]           phase,         // phase
    input wire logic                 cycle_start,   // cycle start
    input wire logic                 discard_fetch, // added cycle
    input wire logic [`WORD_W-1:0]   exec_word,     // word
    input wire logic [`CYCLES_W-1:0] exec_cycles,   // cycle count
    input wire logic                 file_read,     // read strobe
    input wire logic                 file_write,    // file strobe
    input wire logic                 working_write  // working strobe
);
    // one domain, so reset silences every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    phase_walk_a: assert property (cycle_start |-> ##1 phase == 2'h1 ##2 phase == 2'h3
        ##1 cycle_start) else $error("phase walk");
    start_zero_a: assert property (cycle_start |-> phase == 2'h0) else $error("start");
    read_slot_a: assert property (file_read |-> phase == 2'h1) else $error("read");
    read_first_a: assert property (file_write |-> $past(file_read, 2)) else $error("rmw");
    added_quiet_a: assert property (discard_fetch |-> !(file_write || working_write))
        else $error("added write");
    dest_route_a: assert property (working_write |-> !exec_word[7]) else $error("dest");
    hold_word_a: assert property (phase != 2'h0 |-> $stable(exec_word)) else $error("hold");
    two_cycle_a: assert property (cycle_start && !discard_fetch && exec_cycles == 2'h2
        |-> ##4 discard_fetch ##4 !discard_fetch) else $error("two cycles");
    cover property (cycle_start && exec_cycles == 2'h3);
    cover property (working_write);
    cover property (cycle_start && discard_fetch);
endmodule
bind instruction_word_decoder instr_decoder_checker i_chk (.clk(clk), .rst(rst), .phase(phase),
    .cycle_start(cycle_start), .discard_fetch(discard_fetch), .exec_word(exec_word),
    .exec_cycles(exec_cycles), .file_read(file_read), .file_write(file_write),
    .working_write(working_write));

// file: tb/instruction_word_decoder_tb.sv
`timescale 1ns/10ps
`include "instr_decoder_regs.svh"
module instruction_word_decoder_tb;
    logic                 clk = 1'b0;            // 250 MHz
    logic                 rst;                   // reset
    logic [1:0]           ptr_in_prog;           // pointers aiming at program memory
    logic [`WORD_W-1:0]   instr_word, exec_word; // fetched and executing words
    logic [`CYCLES_W-1:0] exec_cycles;           // cycles of executing word
    logic                 cycle_start, fetch_request, discard_fetch;
    logic                 file_read, file_write, working_write;
    wire [31:0]           fld;                   // fields
    int                   fail_count, checks, wp; // wp: next program slot
    always #2 clk = ~clk;
    instruction_word_decoder i_instruction_word_decoder (.clk(clk), .rst(rst),
        .instr_word(instr_word), .ptr_in_prog(ptr_in_prog), .phase(), .cycle_start(cycle_start),
        .fetch_request(fetch_request), .discard_fetch(discard_fetch), .exec_word(exec_word),
        .exec_group(), .exec_file_addr(fld[31:25]), .exec_dest_file(), .exec_lit8(),
        .exec_bit_pos(fld[24:22]), .exec_lit11(fld[21:11]), .exec_lit9(fld[10:2]),
        .exec_ptr_num(), .exec_inc_mode(fld[1:0]), .exec_is_call(),
        .exec_is_return(), .exec_is_branch(), .exec_ind_prog(), .exec_cycles(exec_cycles),
        .file_read(file_read), .file_write(file_write), .working_write(working_write));
    prog_memory_model i_prog_memory_model (.clk(clk), .rst(rst), .fetch_request(fetch_request),
        .instr_word(instr_word));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // judge one word: fields at its start, then its length and strobe counts
    task automatic step(input logic [13:0] w, input logic [4:0] x);
        int n = 0, rd = 0, fw = 0, ww = 0;
        check("exec_word", exec_word, w);
        check("exec_cycles", exec_cycles, x[4:3]);
        check("fields", fld, {w[6:0], w[9:7], w[10:0], w[8:0], w[1:0]});
        do begin
            rd += (file_read === 1'b1);
            fw += (file_write === 1'b1);
            ww += (working_write === 1'b1);
            @(negedge clk);
            n++;
        end while (!(cycle_start === 1'b1 && discard_fetch === 1'b0) && n < 16);
        check("clocks", n, 4 * x[4:3]);
        check("file_read", rd, x[2]);
        check("file_write", fw, x[1]);
        check("working_write", ww, x[0]);
        if (n >= 16) end_sim();
    endtask
    // x is {cycles, read, file write, working write}; skipped slots hold a word that must not run
    task automatic run_table(input logic [13:0] w[$], input logic [4:0] x[$]);
        for (int i = 0; i < w.size(); i++) begin
            i_prog_memory_model.mem[wp] = w[i];
            for (int k = 1; k < x[i][4:3]; k++) i_prog_memory_model.mem[wp + k] = 14'h3fff;
            wp += x[i][4:3];
        end
        step(14'h0000, 5'h08);
        foreach (w[i]) step(w[i], x[i]);
        wp++;
    endtask
    // one-cycle file ops, both destinations, don't-care bits set and clear
    task automatic run_byte_ops;
        ptr_in_prog = 2'b10;
        run_table('{14'h07ff, 14'h077f, 14'h0100, 14'h0103, 14'h1725, 14'h00a5},
            '{5'h0e, 5'h0d, 5'h0d, 5'h0d, 5'h0e, 5'h0e});
    endtask
    // every call, return, jump, branch and skip
    task automatic run_multi_cycle;
        ptr_in_prog = 2'b00;
        run_table('{14'h2000, 14'h000a, 14'h0008, 14'h0009, 14'h3455, 14'h2abc,
            14'h33ff, 14'h000b, 14'h1fa5, 14'h1b25, 14'h0bff, 14'h0f7f},
            '{5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h14, 5'h14, 5'h16, 5'h15});
    endtask
    // only pointer 0 aims at program memory, so only its references stretch
    task automatic run_indirect;
        ptr_in_prog = 2'b01;
        run_table('{14'h0800, 14'h0b80, 14'h0881, 14'h0012, 14'h3fc5},
            '{5'h15, 5'h1e, 5'h0e, 5'h10, 5'h08});
    endtask
    initial begin
        rst = 1'b1;
        ptr_in_prog = 2'b00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        run_byte_ops();
        run_multi_cycle();
        run_indirect();
        end_sim();
    end
endmodule

// file: tb/prog_memory_model.sv
`timescale 1ns/10ps
`include "instr_decoder_regs.svh"
module prog_memory_model (
    input wire logic           clk,           // clock
    input wire logic           rst,           // reset
    input wire logic           fetch_request, // advance
    output logic [`WORD_W-1:0] instr_word     // word at fetch address
);
    logic [`WORD_W-1:0] mem [64]; // program, filled by the bench
    logic [5:0]         pc;       // fetch address
    initial foreach (mem[i]) mem[i] = '0;
    // every fetch advances, added cycles too, so the word behind a branch is skipped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pc <= 6'h00;
        else if (fetch_request) pc <= pc + 6'h01;
    end
    assign instr_word = mem[pc];
endmodule
